// [ctp_pkg.sv]
package ctp_pkg;
	// wishbone register byte offsets
	localparam logic [3:0] CTP_ADR_CTRL = 4'h0;
	localparam logic [3:0] CTP_ADR_STATUS = 4'h4;
	localparam logic [3:0] CTP_ADR_RXDATA = 4'h8;
	// control and status field positions
	localparam int CTP_CTRL_INITDONE_EN = 0;
	localparam int CTP_CTRL_USRCLK_EN = 1;
	localparam int CTP_CTRL_GOE_EN = 2;
	localparam int CTP_CTRL_GCLR_EN = 3;
	localparam int CTP_CTRL_AS_TRI = 4;
	localparam int CTP_STAT_OVF = 8;
	// reset values, counts and instruction codes
	localparam logic [4:0] CTP_CTRL_RST = 5'h00;
	localparam logic [7:0] CTP_INIT_CYCLES = 8'h10;
	localparam int CTP_FIFO_DEPTH = 8;
	localparam int CTP_DR_W = 8;
	localparam int CTP_IR_W = 4;
	localparam logic [3:0] CTP_IR_CAPTURE = 4'h1;
	localparam logic [3:0] CTP_IR_USERDATA = 4'h2;
	localparam logic [3:0] CTP_IR_BYPASS = 4'hF;
	// option bits as loaded with the first frame
	typedef struct packed {
		logic as_tri;
		logic gclr_en;
		logic goe_en;
		logic usrclk_en;
		logic initdone_en;
	} ctp_opt_t;
	// configuration progress
	typedef enum logic [1:0] {CTP_CFG_IDLE, CTP_CFG_LOAD, CTP_CFG_INIT, CTP_CFG_USER} ctp_cfg_t;
	// boundary-scan controller states
	typedef enum logic [3:0] {
		TAP_TLR, TAP_RTI, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PA_DR,
		TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR,
		TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
	} ctp_tap_t;
endpackage

// [ctp_cfg_tap.sv]
// Summary of operation
// - disabled optional pins float with weak pull-up while configuring
// - serial config pins high impedance in user mode
// - start-up clock times initialization when enabled
// - init-done floats while request low, early
// - init-done driven low after first frame
// - release init-done exactly when user mode starts
// - output-enable low forces all pins high impedance
// - clear input low holds all registers cleared
// - test data sampled on rising test clock
// - test data output changes on falling edge
// - test data output floats unless shifting
// - mode select sampled on rising test clock
// - controller moves on following falling edge
// - test clock clocks scan logic, both edges; here both edges are found by sampling it on the system clock
// - test reset low resets scan logic asynchronously; here it passes the synchroniser and acts on the system clock
`timescale 1ns/100ps
`default_nettype none

module ctp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [WIDTH-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	output logic [WIDTH-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];     // storage words
	logic [AW-1:0] wr_ff;                 // write pointer
	logic [AW-1:0] rd_ff;                 // read pointer
	logic [AW:0] cnt_ff;                  // fill level
	logic push;
	logic pop;
	assign in_ready_o = (cnt_ff != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_ff != '0);
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;
	assign out_data_o = mem_ff[rd_ff];
	// storage write
	always_ff @(posedge clk_i) begin
		if (ce_i && push) begin
			mem_ff[wr_ff] <= in_data_i;
		end
	end
	// pointers and level
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
		end else if (ce_i) begin
			if (push) begin
				wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
			end
			if (pop) begin
				rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
			end
			cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

module ctp_cfg_tap (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// classic wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// configuration side
	input wire logic configuration_request_n_i,
	input wire logic cfg_first_frame_i,
	input wire logic cfg_load_done_i,
	input wire logic user_startup_clock_i,
	input wire logic global_output_enable_i,
	input wire logic global_register_clear_n_i,
	output logic init_done_o,
	output logic init_done_oe_o,
	output logic [3:0] opt_pin_pullup_o,
	output logic as_pins_hiz_o,
	output logic io_output_allow_o,
	output logic reg_clear_o,
	output logic user_mode_o,
	// test access port pins
	input wire logic tck_i,
	input wire logic tms_i,
	input wire logic tdi_i,
	input wire logic trst_n_i,
	output logic tdo_o,
	output logic tdo_oe_o
);
	import ctp_pkg::*;

	// two-stage synchronisers for every pin input
	logic [6:0] pin_raw;
	logic [6:0] sync1_ff;
	logic [6:0] sync2_ff;
	logic tck_d_ff;                      // previous synced test clock
	assign pin_raw = {tck_i, tms_i, tdi_i, trst_n_i, configuration_request_n_i,
		user_startup_clock_i, global_output_enable_i};
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_ff <= 7'h00;
			sync2_ff <= 7'h00;
		end else if (ce_i) begin
			sync1_ff <= pin_raw;
			sync2_ff <= sync1_ff;
		end
	end
	logic tck_s, tms_s, tdi_s, trst_n_s, cfg_req_n_s, usrclk_s, goe_s;
	assign {tck_s, tms_s, tdi_s, trst_n_s, cfg_req_n_s, usrclk_s, goe_s} = sync2_ff;

	// clear input also has its own synchroniser pair
	logic gclr1_ff;
	logic gclr2_ff;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gclr1_ff <= 1'b1;
			gclr2_ff <= 1'b1;
		end else if (ce_i) begin
			gclr1_ff <= global_register_clear_n_i;
			gclr2_ff <= gclr1_ff;
		end
	end

	// edge finder for test clock and start-up clock
	logic usr_d_ff;
	logic tck_rise, tck_fall, usr_rise;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tck_d_ff <= 1'b0;
			usr_d_ff <= 1'b0;
		end else if (ce_i) begin
			tck_d_ff <= tck_s;
			usr_d_ff <= usrclk_s;
		end
	end
	assign tck_rise = tck_s & ~tck_d_ff;
	assign tck_fall = ~tck_s & tck_d_ff;
	assign usr_rise = usrclk_s & ~usr_d_ff;

	// software control register and loaded options
	logic [4:0] ctrl_ff;                 // options written by software
	ctp_opt_t opt_ff;                    // options in force for this configuration
	logic ovf_ff;                        // scan word dropped, fifo full
	logic wb_req, wb_wr, wb_rd_data;
	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wb_wr = wb_req & wb_we_i;
	assign wb_rd_data = wb_req & ~wb_we_i & (wb_adr_i == CTP_ADR_RXDATA);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_ff <= CTP_CTRL_RST;
		end else if (ce_i && wb_wr && wb_adr_i == CTP_ADR_CTRL && wb_sel_i[0]) begin
			ctrl_ff <= wb_dat_i[4:0];
		end
	end

	// configuration sequencer
	ctp_cfg_t cfg_ff;
	logic [7:0] init_cnt_ff;             // start-up or system clock ticks remaining
	logic init_tick;
	assign init_tick = opt_ff.usrclk_en ? usr_rise : 1'b1;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_ff <= CTP_CFG_IDLE;
			opt_ff <= '0;
			init_cnt_ff <= 8'h00;
		end else if (ce_i) begin
			if (!cfg_req_n_s) begin
				// request low: start over, options gone
				cfg_ff <= CTP_CFG_IDLE;
				opt_ff <= '0;
			end else begin
				case (cfg_ff)
					CTP_CFG_IDLE: begin
						if (cfg_first_frame_i) begin
							opt_ff <= ctp_opt_t'(ctrl_ff);
							cfg_ff <= CTP_CFG_LOAD;
						end
					end
					CTP_CFG_LOAD: begin
						if (cfg_load_done_i) begin
							init_cnt_ff <= CTP_INIT_CYCLES;
							cfg_ff <= CTP_CFG_INIT;
						end
					end
					CTP_CFG_INIT: begin
						if (init_tick) begin
							init_cnt_ff <= init_cnt_ff - 8'h01;
							if (init_cnt_ff == 8'h01) begin
								cfg_ff <= CTP_CFG_USER;
							end
						end
					end
					CTP_CFG_USER: begin
						cfg_ff <= CTP_CFG_USER;
					end
					default: begin
						cfg_ff <= CTP_CFG_IDLE;
					end
				endcase
			end
		end
	end
	logic in_cfg;
	assign in_cfg = (cfg_ff != CTP_CFG_USER);
	assign user_mode_o = ~in_cfg;
	// open-drain status: driven low from first frame until user mode
	assign init_done_o = 1'b0;
	assign init_done_oe_o = opt_ff.initdone_en &
		(cfg_ff == CTP_CFG_LOAD || cfg_ff == CTP_CFG_INIT);
	// disabled optional pins: user pins, pulled up while configuring
	assign opt_pin_pullup_o = {4{in_cfg}} & ~{opt_ff.gclr_en, opt_ff.goe_en,
		opt_ff.initdone_en, opt_ff.usrclk_en};
	assign as_pins_hiz_o = user_mode_o & opt_ff.as_tri;
	assign io_output_allow_o = ~(opt_ff.goe_en & ~goe_s);
	assign reg_clear_o = opt_ff.gclr_en & ~gclr2_ff;

	// test access port controller
	ctp_tap_t tap_ff;
	logic tms_l_ff;                      // mode select caught at rising edge
	logic [CTP_IR_W-1:0] ir_sh_ff;       // instruction shift register
	logic [CTP_IR_W-1:0] ir_ff;          // current instruction
	logic [CTP_DR_W-1:0] dr_sh_ff;       // user data shift register
	logic byp_ff;                        // bypass bit
	logic tdo_ff, tdo_oe_ff;
	ctp_tap_t nxt_tap; // state taken at the coming fall
	logic tap_rst;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [CTP_DR_W-1:0] fifo_out_data;
	logic push_req;
	assign tap_rst = rst_i | ~trst_n_s;

	// standard controller transition
	function automatic ctp_tap_t tap_next(input ctp_tap_t s, input logic m);
		case (s)
			TAP_TLR: tap_next = m ? TAP_TLR : TAP_RTI;
			TAP_RTI: tap_next = m ? TAP_SEL_DR : TAP_RTI;
			TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
			TAP_SH_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
			TAP_EX1_DR: tap_next = m ? TAP_UPD_DR : TAP_PA_DR;
			TAP_PA_DR: tap_next = m ? TAP_EX2_DR : TAP_PA_DR;
			TAP_EX2_DR: tap_next = m ? TAP_UPD_DR : TAP_SH_DR;
			TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_RTI;
			TAP_SEL_IR: tap_next = m ? TAP_TLR : TAP_CAP_IR;
			TAP_CAP_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
			TAP_SH_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
			TAP_EX1_IR: tap_next = m ? TAP_UPD_IR : TAP_PA_IR;
			TAP_PA_IR: tap_next = m ? TAP_EX2_IR : TAP_PA_IR;
			TAP_EX2_IR: tap_next = m ? TAP_UPD_IR : TAP_SH_IR;
			TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_RTI;
			default: tap_next = TAP_TLR;
		endcase
	endfunction
	// output enable and bit follow the state being entered, not the one left
	assign nxt_tap = tap_next(tap_ff, tms_l_ff);

	// rising test clock: sample mode select and shift data in
	always_ff @(posedge clk_i) begin
		if (tap_rst) begin
			tms_l_ff <= 1'b1;
			ir_sh_ff <= '0;
			dr_sh_ff <= '0;
			byp_ff <= 1'b0;
		end else if (ce_i && tck_rise) begin
			tms_l_ff <= tms_s;
			case (tap_ff)
				TAP_CAP_IR: ir_sh_ff <= CTP_IR_CAPTURE;
				TAP_SH_IR: ir_sh_ff <= {tdi_s, ir_sh_ff[CTP_IR_W-1:1]};
				TAP_CAP_DR: begin
					dr_sh_ff <= {5'h00, ovf_ff, cfg_ff};
					byp_ff <= 1'b0;
				end
				TAP_SH_DR: begin
					dr_sh_ff <= {tdi_s, dr_sh_ff[CTP_DR_W-1:1]};
					byp_ff <= tdi_s;
				end
				default: begin
					byp_ff <= byp_ff;
				end
			endcase
		end
	end

	// falling test clock: state change, instruction update, output bit
	always_ff @(posedge clk_i) begin
		if (tap_rst) begin
			tap_ff <= TAP_TLR;
			ir_ff <= CTP_IR_BYPASS;
			tdo_ff <= 1'b0;
			tdo_oe_ff <= 1'b0;
		end else if (ce_i && tck_fall) begin
			tap_ff <= nxt_tap;
			if (tap_ff == TAP_UPD_IR) begin
				ir_ff <= ir_sh_ff;
			end
			// first bit out on the fall into shift, float on the fall out of it
			tdo_oe_ff <= (nxt_tap == TAP_SH_DR) || (nxt_tap == TAP_SH_IR);
			if (nxt_tap == TAP_SH_IR) begin
				tdo_ff <= ir_sh_ff[0];
			end else if (ir_ff == CTP_IR_USERDATA || ir_ff == CTP_IR_CAPTURE) begin
				tdo_ff <= dr_sh_ff[0];
			end else begin
				tdo_ff <= byp_ff;
			end
		end
	end
	assign tdo_o = tdo_ff;
	assign tdo_oe_o = tdo_oe_ff;

	// user data word leaves on the fall out of update-dr
	assign push_req = ce_i & tck_fall & (tap_ff == TAP_UPD_DR) & (ir_ff == CTP_IR_USERDATA);

	ctp_fifo #(
		.WIDTH(CTP_DR_W),
		.DEPTH(CTP_FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.in_data_i(dr_sh_ff),
		.in_valid_i(push_req),
		.in_ready_o(fifo_in_ready),
		.out_data_o(fifo_out_data),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(wb_rd_data)
	);

	// overflow flag: a full fifo drops the word; set wins over clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ovf_ff <= 1'b0;
		end else if (ce_i) begin
			if (push_req && !fifo_in_ready) begin
				ovf_ff <= 1'b1;
			end else if (wb_wr && wb_adr_i == CTP_ADR_STATUS && wb_sel_i[1] &&
				wb_dat_i[CTP_STAT_OVF]) begin
				ovf_ff <= 1'b0;
			end
		end
	end

	// wishbone answer: ack one cycle after the request, read data registered
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (wb_adr_i)
			CTP_ADR_CTRL: rd_mux = {27'h0, ctrl_ff};
			CTP_ADR_STATUS: rd_mux = {16'h0, 3'h0, fifo_in_ready, tap_ff, ovf_ff,
				fifo_out_valid, 1'b0, init_done_oe_o, opt_ff.usrclk_en, user_mode_o,
				cfg_ff};
			CTP_ADR_RXDATA: rd_mux = {23'h0, fifo_out_valid, fifo_out_data};
			default: rd_mux = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else if (ce_i) begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i) begin
				wb_dat_o <= rd_mux;
			end
		end
	end
endmodule

`default_nettype wire

// [ctp_cfg_tap_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
// pin-level checks on the config and test port block
module ctp_cfg_tap_asserts (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_ack_o,
	input wire logic configuration_request_n_i,
	input wire logic global_output_enable_i,
	input wire logic global_register_clear_n_i,
	input wire logic init_done_oe_o,
	input wire logic [3:0] opt_pin_pullup_o,
	input wire logic as_pins_hiz_o,
	input wire logic io_output_allow_o,
	input wire logic reg_clear_o,
	input wire logic user_mode_o,
	input wire logic tck_i,
	input wire logic trst_n_i,
	input wire logic tdo_o,
	input wire logic tdo_oe_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	pullup_off_a: assert property (user_mode_o |-> opt_pin_pullup_o == 4'h0)
		else $error("pull-up on in user mode");
	as_hiz_a: assert property (as_pins_hiz_o |-> user_mode_o)
		else $error("serial pins floated outside user mode");
	req_idle_a: assert property (!configuration_request_n_i [*5] |->
		!init_done_oe_o && !user_mode_o) else $error("done driven while request low");
	done_rel_a: assert property ($fell(init_done_oe_o) && configuration_request_n_i |->
		$rose(user_mode_o)) else $error("done released apart from user mode");
	goe_pass_a: assert property (global_output_enable_i [*4] |-> io_output_allow_o)
		else $error("outputs blocked with enable high");
	gclr_pass_a: assert property (global_register_clear_n_i [*4] |-> !reg_clear_o)
		else $error("clear with clear pin high");
	tdo_fall_a: assert property ($changed({tdo_o, tdo_oe_o}) |-> !tck_i)
		else $error("test data out moved with test clock high");
	trst_idle_a: assert property (!trst_n_i [*5] |-> !tdo_oe_o)
		else $error("test data out driven in test reset");
endmodule
bind ctp_cfg_tap ctp_cfg_tap_asserts ctp_cfg_tap_asserts_inst (.*);
`default_nettype wire

// [ctp_jtag_host.sv]
`timescale 1ns/100ps
`default_nettype none
// test host: bit-bangs the test port at a tenth of the system clock
module ctp_jtag_host (
	input wire logic clk_i,
	input wire logic tdo_i,
	output logic tck_o,
	output logic tms_o,
	output logic tdi_o,
	output logic trst_n_o
);
	// idle: clock still low, pulled-up lines high
	initial begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b1;
		trst_n_o = 1'b1;
	end
	// n bits lsb first, tdo taken at each rise
	task automatic seq(input logic [31:0] tms, input logic [31:0] tdi, input int n,
		output logic [31:0] tdo);
		tdo = '0;
		for (int i = 0; i < n; i++) begin
			@(posedge clk_i);
			tms_o <= tms[i];
			tdi_o <= tdi[i];
			repeat (5) @(posedge clk_i);
			tck_o <= 1'b1;
			tdo[i] = tdo_i;
			repeat (4) @(posedge clk_i);
			tck_o <= 1'b0;
		end
		// let the block see the last fall before handing back
		repeat (4) @(posedge clk_i);
		tms_o <= 1'b1;
		tdi_o <= 1'b1;
	endtask
	// test reset, mode select held high over release
	task automatic tap_reset();
		@(posedge clk_i);
		trst_n_o <= 1'b0;
		repeat (8) @(posedge clk_i);
		trst_n_o <= 1'b1;
	endtask
endmodule
`default_nettype wire

// [ctp_cfg_tap_tb.sv]
`timescale 1ns/100ps
`default_nettype none
// bench for the config and test port block
module ctp_cfg_tap_tb;
	import ctp_pkg::*;
	// byte shifted in, word read back
	typedef struct packed {
		logic [7:0] d;
		logic [8:0] q;
	} ctp_row_t;
	ctp_row_t rows [4] = '{'{8'h00, 9'h100}, '{8'hA5, 9'h1A5}, '{8'hFF, 9'h1FF}, '{8'h3C, 9'h13C}};
	logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0, wb_ack_o, init_done_o, init_done_oe_o, as_pins_hiz_o;
	logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hF, opt_pin_pullup_o;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
	logic configuration_request_n_i = 1'b1, cfg_first_frame_i = 1'b0, cfg_load_done_i = 1'b0;
	logic user_startup_clock_i = 1'b0, global_output_enable_i = 1'b1;
	logic global_register_clear_n_i = 1'b1, io_output_allow_o, reg_clear_o, user_mode_o;
	logic tck_i, tms_i, tdi_i, trst_n_i, tdo_o, tdo_oe_o, tdo_last = 1'b0, tdo_w, done_w;
	int errors = 0, tests_run = 0;
	always #4 clk_i = ~clk_i;
	// released test data line shows the inverse of its last value
	always_ff @(posedge clk_i) if (tdo_oe_o) tdo_last <= tdo_o;
	assign tdo_w = tdo_oe_o ? tdo_o : ~tdo_last;
	// open-drain done pin with board pull-up
	assign done_w = init_done_oe_o ? init_done_o : 1'b1;
	ctp_cfg_tap ctp_cfg_tap_inst (.*);
	ctp_jtag_host ctp_jtag_host_inst (.clk_i(clk_i), .tdo_i(tdo_w), .tck_o(tck_i),
		.tms_o(tms_i), .tdi_o(tdi_i), .trst_n_o(trst_n_i));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic close_out();
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// classic single cycle, waits for ack
	task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		@(posedge clk_i);
		// ack ends this wait; without ack only the watchdog does
		while (wb_ack_o !== 1'b1) begin
			@(posedge clk_i);
		end
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	// user data instruction, one byte in, update pushes it
	task automatic push(input logic [7:0] d);
		logic [31:0] t;
		ctp_jtag_host_inst.seq(32'h0600E0DF, (32'(d) << 18) | 32'h800, 28, t);
		chk("ir capture out", 32'h1, (t >> 10) & 32'hF);
		chk("tdo idle", 0, tdo_oe_o);
	endtask
	initial begin
		repeat (40000) @(posedge clk_i);
		errors++;
		close_out();
	end
	initial begin
		int n;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk("pullup", 32'hF, opt_pin_pullup_o);
		chk("serial hiz", 0, as_pins_hiz_o);
		wb(1'b0, CTP_ADR_CTRL, 0);
		chk("ctrl reset", 0, q);
		wb(1'b0, 4'hC, 0);
		chk("unmapped", 0, q);
		foreach (rows[i]) begin
			push(rows[i].d);
			wb(1'b0, CTP_ADR_RXDATA, 0);
			chk("rx word", rows[i].q, q & 32'h1FF);
		end
		// nine words into eight places
		for (int i = 0; i < 9; i++) push(8'h10 + 8'(i));
		wb(1'b0, CTP_ADR_STATUS, 0);
		chk("overflow", 1, q[CTP_STAT_OVF-1]);
		// write one to clear the overflow flag
		wb(1'b1, CTP_ADR_STATUS, 32'h1 << CTP_STAT_OVF);
		wb(1'b0, CTP_ADR_STATUS, 0);
		chk("overflow clear", 0, q[CTP_STAT_OVF-1]);
		for (int i = 0; i < 9; i++) begin
			wb(1'b0, CTP_ADR_RXDATA, 0);
			chk("drain", (i < 8) ? 32'h110 + i : 0, (i < 8) ? q & 32'h1FF : q[8]);
		end
		// park in shift-DR, then test reset
		ctp_jtag_host_inst.seq(32'h5F, 0, 9, q);
		repeat (6) @(posedge clk_i);
		chk("tdo shifting", 1, tdo_oe_o);
		ctp_jtag_host_inst.tap_reset();
		chk("tdo after trst", 0, tdo_oe_o);
		// all options, timed from the start-up clock
		wb(1'b1, CTP_ADR_CTRL, 32'h1F);
		@(posedge clk_i) cfg_first_frame_i <= 1'b1;
		@(posedge clk_i) cfg_first_frame_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk("done low", 0, done_w);
		chk("pullup off", 0, opt_pin_pullup_o);
		@(posedge clk_i) cfg_load_done_i <= 1'b1;
		@(posedge clk_i) cfg_load_done_i <= 1'b0;
		for (int i = 0; i < 31; i++) begin
			repeat (5) @(posedge clk_i);
			user_startup_clock_i <= ~user_startup_clock_i;
			if (i == 29) chk("early user", 0, user_mode_o);
		end
		n = 0;
		while (user_mode_o !== 1'b1 && n < 10) begin
			@(posedge clk_i);
			n++;
		end
		chk("done high at user", 1, done_w & user_mode_o);
		chk("serial hiz user", 1, as_pins_hiz_o);
		// clock enable low freezes the pin synchronisers
		ce_i <= 1'b0;
		global_output_enable_i <= 1'b0;
		global_register_clear_n_i <= 1'b0;
		repeat (5) @(posedge clk_i);
		chk("frozen io", 1, io_output_allow_o);
		ce_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		chk("io blocked", 0, io_output_allow_o);
		chk("reg clear", 1, reg_clear_o);
		global_output_enable_i <= 1'b1;
		global_register_clear_n_i <= 1'b1;
		configuration_request_n_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		chk("request low", 0, user_mode_o | init_done_oe_o);
		configuration_request_n_i <= 1'b1;
		// done pin only, initialization timed by the system clock
		wb(1'b1, CTP_ADR_CTRL, 32'h01);
		@(posedge clk_i) cfg_first_frame_i <= 1'b1;
		@(posedge clk_i) cfg_first_frame_i <= 1'b0;
		@(posedge clk_i) cfg_load_done_i <= 1'b1;
		chk("pullup partial", 32'hD, opt_pin_pullup_o);
		@(posedge clk_i) cfg_load_done_i <= 1'b0;
		repeat (int'(CTP_INIT_CYCLES)) @(posedge clk_i);
		chk("init count", 0, user_mode_o);
		@(posedge clk_i);
		chk("init end", 1, user_mode_o & done_w);
		chk("serial pins user", 0, as_pins_hiz_o);
		close_out();
	end
endmodule
`default_nettype wire
